// ==== core/mdd_defs.svh ====
`ifndef MDD_DEFS_SVH
`define MDD_DEFS_SVH

// ****************************************************************
// Clock and rates.
// ****************************************************************
`define MDD_CLK_HZ 10000000
`define MDD_SAMPLE_DIV 8
`define MDD_WORD_DIV 1024
`define MDD_CNT_BITS 10
`define MDD_SAMPLE_PHASE 3'h7
`define MDD_DUMP_PHASE 10'h3ff

// ****************************************************************
// Word and field layout.
// ****************************************************************
`define MDD_WORD_BITS 24
`define MDD_FINE_BITS 9
`define MDD_COARSE_BITS 2
`define MDD_FINE_STEP_CYC (`MDD_WORD_DIV / (1 << `MDD_FINE_BITS))
`define MDD_DELAY_LEN (`MDD_FINE_STEP_CYC * ((1 << `MDD_FINE_BITS) - 1))
`define MDD_COARSE_CURR_CODE 2'h3

// ****************************************************************
// Filter constants.
// ****************************************************************
`define MDD_CIC_SCALE 2
`define MDD_IIR_SHIFT 3
`define MDD_HPF_CORNER_MHZ 2000
`define MDD_HPF_ACC_BITS 36
`define MDD_GAIN_FRAC 22

// ****************************************************************
// Reset values.
// ****************************************************************
`define MDD_RESET_WORD 24'h000000
`define MDD_RESET_BYPASS 1'b0

`endif

// ==== core/mdd_pkg.sv ====
`include "mdd_defs.svh"

package mdd_pkg;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef logic signed [`MDD_WORD_BITS-1:0] mdd_word_t;

  typedef struct packed {
    mdd_word_t int1;
    mdd_word_t int2;
    mdd_word_t int3;
    mdd_word_t comb1;
    mdd_word_t comb2;
    mdd_word_t comb3;
    mdd_word_t iir;
    mdd_word_t word;
    logic valid;
  } mdd_dec_s;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [`MDD_CNT_BITS-1:0] cnt;
    logic [`MDD_DELAY_LEN-1:0] dly;
    logic [`MDD_COARSE_BITS-1:0] coarse;
    logic [`MDD_FINE_BITS-1:0] fine;
    logic bypass;
    logic [1:0][1:0][`MDD_WORD_BITS-1:0] hist;
    logic [1:0][`MDD_HPF_ACC_BITS-1:0] dc_acc;
    logic [1:0][`MDD_HPF_ACC_BITS-1:0] pm_acc;
    logic strobe;
    logic [1:0][`MDD_WORD_BITS-1:0] smp;
  } mdd_top_s;

  // ****************************************************************
  // Saturation of a wide signed value to one word.
  // ****************************************************************
  function automatic mdd_word_t mdd_sat(input logic signed [49:0] v);
    mdd_word_t r;
    r = v[`MDD_WORD_BITS-1:0];
    if (v > 50'sh00000007fffff) begin
      r = 24'sh7fffff;
    end else if (v < 50'sh3ffffff800000) begin
      r = 24'sh800000;
    end
    return r;
  endfunction

endpackage

// ==== core/mdd_dec_if.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Link between the sequencer and one sinc decimator.
// ****************************************************************
interface mdd_dec_if;
  logic bit_in;
  logic sample_en;
  logic dump;
  logic bypass;
  mdd_pkg::mdd_word_t word;
  logic word_valid;

  modport dec (
    input bit_in,
    input sample_en,
    input dump,
    input bypass,
    output word,
    output word_valid
  );

  modport ctl (
    output bit_in,
    output sample_en,
    output dump,
    output bypass,
    input word,
    input word_valid
  );
endinterface

// ==== core/mdd_decimator.sv ====
`timescale 1ns/1ps
`include "mdd_defs.svh"

module mdd_decimator (
  input wire logic clk,
  input wire logic reset_n,
  mdd_dec_if.dec dec
);

  mdd_pkg::mdd_dec_s st_q;
  mdd_pkg::mdd_dec_s st_d;

  // ****************************************************************
  // Third-order sinc decimator followed by the droop filter.
  // ****************************************************************
  always_comb begin
    mdd_pkg::mdd_word_t x;
    mdd_pkg::mdd_word_t s1;
    mdd_pkg::mdd_word_t s2;
    mdd_pkg::mdd_word_t s3;
    mdd_pkg::mdd_word_t d1;
    mdd_pkg::mdd_word_t d2;
    mdd_pkg::mdd_word_t d3;
    mdd_pkg::mdd_word_t raw;
    logic signed [27:0] wide;
    logic signed [27:0] iir_t;
    x = '0;
    s1 = '0;
    s2 = '0;
    s3 = '0;
    d1 = '0;
    d2 = '0;
    d3 = '0;
    raw = '0;
    wide = '0;
    iir_t = '0;
    st_d = st_q;
    st_d.valid = 1'b0;
    // The single bit maps to plus or minus one.
    x = dec.bit_in ? 24'sh000001 : 24'shffffff;
    s1 = st_q.int1 + x;
    s2 = st_q.int2 + s1;
    s3 = st_q.int3 + s2;
    if (dec.sample_en) begin
      st_d.int1 = s1;
      st_d.int2 = s2;
      st_d.int3 = s3;
    end
    if (dec.dump) begin
      d1 = s3 - st_q.comb1;
      d2 = d1 - st_q.comb2;
      d3 = d2 - st_q.comb3;
      st_d.comb1 = s3;
      st_d.comb2 = d1;
      st_d.comb3 = d2;
      // Gain of the decimator is 2^21, widened here to full scale.
      wide = 28'(d3) <<< `MDD_CIC_SCALE;
      raw = mdd_pkg::mdd_sat(50'(wide));
      // First-order boost of high frequencies with unity gain at DC.
      iir_t = 28'(raw) + ((28'(raw) - 28'(st_q.iir)) >>> `MDD_IIR_SHIFT);
      st_d.word = dec.bypass ? raw : mdd_pkg::mdd_sat(50'(iir_t));
      st_d.iir = st_d.word;
      st_d.valid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dec.word = st_q.word;
  assign dec.word_valid = st_q.valid;

endmodule

// ==== core/mdd_datapath.sv ====
`timescale 1ns/1ps
`include "mdd_defs.svh"

// Contract
// - Each channel bitstream is sampled once every eight master clocks.
// - Both channels take single-bit delta-sigma modulator streams as input.
// - Decimation yields 24-bit words at one word per 1024 clocks.
// - Decimators are third-order sinc filters followed by the droop stage.
// - Droop stage boosts high frequencies to flatten the sinc roll-off.
// - Droop stage active after reset; bypass bit passes decimator words unchanged.
// - Phase compensation delays samples inside each channel path.
// - Current delay uses coarse and fine fields; voltage uses coarse only.
// - Fine field adds up to one word period to current, linearly.
// - Coarse adds one word to current, up to two to voltage.
// - Every sample of each channel gets its own offset and gain.
// - DC-removal high-pass corner lies near 2 Hz.
// - Optional high-pass per channel; phase-matching filter on the other.

module mdd_datapath #(
  parameter int CLK_HZ = `MDD_CLK_HZ,
  parameter int HPF_CORNER_MHZ = `MDD_HPF_CORNER_MHZ
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mod_volt_bit,
  input wire logic mod_curr_bit,
  input wire logic droop_filter_bypass,
  input wire logic [`MDD_COARSE_BITS-1:0] coarse_phase_delay,
  input wire logic [`MDD_FINE_BITS-1:0] fine_phase_delay,
  input wire logic hpf_volt_en,
  input wire logic hpf_curr_en,
  input wire logic pmf_volt_en,
  input wire logic pmf_curr_en,
  input wire logic [`MDD_WORD_BITS-1:0] volt_offset,
  input wire logic [`MDD_WORD_BITS-1:0] curr_offset,
  input wire logic [`MDD_WORD_BITS-1:0] volt_gain,
  input wire logic [`MDD_WORD_BITS-1:0] curr_gain,
  output logic sample_strobe,
  output logic [`MDD_WORD_BITS-1:0] volt_sample,
  output logic [`MDD_WORD_BITS-1:0] curr_sample
);

  // ****************************************************************
  // Derived constants.
  // ****************************************************************
  // Output word rate in hertz and the shift that puts the one-pole
  // corner near the wanted frequency: corner = rate / (2 pi 2^k).
  localparam int OWR_HZ = CLK_HZ / `MDD_WORD_DIV;
  localparam int HPF_SHIFT = $clog2((OWR_HZ * 1000) / (6283 * HPF_CORNER_MHZ / 1000));
  localparam int AW = `MDD_HPF_ACC_BITS;
  localparam int WB = `MDD_WORD_BITS;

  mdd_pkg::mdd_top_s q;
  mdd_pkg::mdd_top_s d;

  mdd_dec_if vdec ();
  mdd_dec_if idec ();

  logic sample_en;
  logic dump;
  logic curr_tap;
  logic [`MDD_CNT_BITS-1:0] tap_idx;

  // ****************************************************************
  // Sequencing of samples and words.
  // ****************************************************************
  assign sample_en = (q.cnt[2:0] == `MDD_SAMPLE_PHASE);
  assign dump = (q.cnt == `MDD_DUMP_PHASE);

  // ****************************************************************
  // Fine delay tap on the current bitstream.
  // ****************************************************************
  // Each fine step is two master clocks, so the full field spans one word.
  assign tap_idx = `MDD_CNT_BITS'({q.fine, 1'b0} - 10'h001);
  assign curr_tap = (q.fine == '0) ? q.sync2[1] : q.dly[tap_idx];

  // ****************************************************************
  // Decimator links.
  // ****************************************************************
  assign vdec.bit_in = q.sync2[0];
  assign vdec.sample_en = sample_en;
  assign vdec.dump = dump;
  assign vdec.bypass = q.bypass;
  assign idec.bit_in = curr_tap;
  assign idec.sample_en = sample_en;
  assign idec.dump = dump;
  assign idec.bypass = q.bypass;

  mdd_decimator u_volt_dec (
    .clk(clk),
    .reset_n(reset_n),
    .dec(vdec.dec)
  );

  mdd_decimator u_curr_dec (
    .clk(clk),
    .reset_n(reset_n),
    .dec(idec.dec)
  );

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    logic [1:0][WB-1:0] raw;
    logic [1:0][WB-1:0] offs;
    logic [1:0][WB-1:0] gain;
    logic [1:0] hpf_en;
    logic [1:0] pmf_en;
    logic [1:0][1:0] nwords;
    logic signed [WB-1:0] x;
    logic signed [WB-1:0] dc;
    logic signed [WB-1:0] pm_lp;
    logic signed [AW-1:0] acc;
    logic signed [AW-1:0] pacc;
    logic signed [26:0] filt;
    logic signed [WB-1:0] fsat;
    logic signed [26:0] sum;
    logic signed [WB:0] corr;
    logic signed [49:0] prod;
    raw = '0;
    offs = '0;
    gain = '0;
    hpf_en = '0;
    pmf_en = '0;
    nwords = '0;
    x = '0;
    dc = '0;
    pm_lp = '0;
    acc = '0;
    pacc = '0;
    filt = '0;
    fsat = '0;
    sum = '0;
    corr = '0;
    prod = '0;
    d = q;
    d.strobe = 1'b0;
    // Modulator bits come from pins and pass two flip-flops.
    d.sync1 = {mod_curr_bit, mod_volt_bit};
    d.sync2 = q.sync1;
    d.cnt = q.cnt + `MDD_CNT_BITS'(1);
    d.dly = {q.dly[`MDD_DELAY_LEN-2:0], q.sync2[1]};
    if (dump) begin
      d.coarse = coarse_phase_delay;
      d.fine = fine_phase_delay;
      d.bypass = droop_filter_bypass;
    end
    raw[0] = vdec.word;
    raw[1] = idec.word;
    offs[0] = volt_offset;
    offs[1] = curr_offset;
    gain[0] = volt_gain;
    gain[1] = curr_gain;
    hpf_en[0] = hpf_volt_en;
    hpf_en[1] = hpf_curr_en;
    pmf_en[0] = pmf_volt_en;
    pmf_en[1] = pmf_curr_en;
    // Coarse code 3 delays current by one word; codes 0 to 2 delay voltage by that many words.
    nwords[0] = (q.coarse == `MDD_COARSE_CURR_CODE) ? 2'h0 : q.coarse;
    nwords[1] = (q.coarse == `MDD_COARSE_CURR_CODE) ? 2'h1 : 2'h0;
    if (vdec.word_valid) begin
      d.strobe = 1'b1;
      for (int ch = 0; ch < 2; ch++) begin
        // Whole-word delay from the short history of past words.
        d.hist[ch][0] = raw[ch];
        d.hist[ch][1] = q.hist[ch][0];
        case (nwords[ch])
          2'h0: x = $signed(raw[ch]);
          2'h1: x = $signed(q.hist[ch][0]);
          2'h2: x = $signed(q.hist[ch][1]);
          default: x = $signed(q.hist[ch][1]);
        endcase
        // One-pole DC tracker; the high-pass output is input minus DC.
        acc = $signed(q.dc_acc[ch]);
        dc = WB'(acc >>> HPF_SHIFT);
        d.dc_acc[ch] = AW'(acc + AW'(x) - AW'(dc));
        // A second tracker on the DC estimate restores DC for phase matching.
        pacc = $signed(q.pm_acc[ch]);
        pm_lp = WB'(pacc >>> HPF_SHIFT);
        d.pm_acc[ch] = AW'(pacc + AW'(dc) - AW'(pm_lp));
        if (hpf_en[ch]) begin
          filt = 27'(x) - 27'(dc);
        end else if (pmf_en[ch]) begin
          filt = 27'(x) - 27'(dc) + 27'(pm_lp);
        end else begin
          filt = 27'(x);
        end
        fsat = mdd_pkg::mdd_sat(50'(filt));
        // Offset first, then gain in unsigned 2.22 format.
        sum = 27'(fsat) + 27'($signed(offs[ch]));
        corr = (WB+1)'(mdd_pkg::mdd_sat(50'(sum)));
        prod = 50'(corr) * 50'($signed({1'b0, gain[ch]}));
        d.smp[ch] = mdd_pkg::mdd_sat(prod >>> `MDD_GAIN_FRAC);
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.bypass <= `MDD_RESET_BYPASS;
      q.smp <= {`MDD_RESET_WORD, `MDD_RESET_WORD};
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign sample_strobe = q.strobe;
  assign volt_sample = q.smp[0];
  assign curr_sample = q.smp[1];

endmodule

// ==== tb/mdd_modulator_model.sv ====
`timescale 1ns/1ps

// ****
// Modulator pair: one bit per channel, held for eight clocks.
// ****
module mdd_modulator_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic volt_level,
  input wire logic curr_level,
  output logic volt_bit,
  output logic curr_bit
);
  logic [2:0] div_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 3'h0;
      volt_bit <= 1'b0;
      curr_bit <= 1'b1;
    end else begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h0) begin
        volt_bit <= volt_level;
        curr_bit <= curr_level;
      end
    end
  end
endmodule

// ==== tb/mdd_datapath_asserts.sv ====
`timescale 1ns/1ps
`include "mdd_defs.svh"

// ****
// Output timing of the datapath.
// ****
module mdd_datapath_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_strobe,
  input wire logic [`MDD_WORD_BITS-1:0] volt_sample,
  input wire logic [`MDD_WORD_BITS-1:0] curr_sample
);
  logic [10:0] cnt_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 11'h000;
    end else begin
      cnt_q <= (cnt_q == 11'h7ff) ? 11'h400 : cnt_q + 11'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_boundary;
    cnt_q[10] && cnt_q[9:0] == 10'h001;
  endsequence

  a_boundary_has_strobe: assert property (s_boundary |-> sample_strobe)
    else $error("strobe missing at word boundary");
  a_strobe_on_boundary: assert property (sample_strobe |-> s_boundary)
    else $error("strobe away from word boundary");
  a_strobe_one_pulse: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("strobe longer than one cycle");
  a_early_quiet: assert property (!cnt_q[10] |-> !sample_strobe)
    else $error("strobe before first word");
  a_release_quiet: assert property ($rose(reset_n) |-> !sample_strobe && volt_sample == 0
    && curr_sample == 0)
    else $error("output active right after reset");
  a_volt_hold: assert property ($changed(volt_sample) |-> sample_strobe)
    else $error("voltage sample changed without strobe");
  a_curr_hold: assert property ($changed(curr_sample) |-> sample_strobe)
    else $error("current sample changed without strobe");
  a_pair_stable: assert property (sample_strobe |=> $stable(volt_sample) && $stable(curr_sample))
    else $error("samples moved after strobe");
endmodule

bind mdd_datapath mdd_datapath_asserts mdd_datapath_asserts_inst (
  .clk(clk),
  .reset_n(reset_n),
  .sample_strobe(sample_strobe),
  .volt_sample(volt_sample),
  .curr_sample(curr_sample)
);

// ==== tb/test_mdd_datapath.sv ====
`timescale 1ns/1ps
`include "mdd_defs.svh"

// ****
// Self-checking bench for the datapath.
// ****
module test_mdd_datapath;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic lv = 1'b0;
  logic lc = 1'b0;
  logic vbit, cbit, strobe;
  logic bypass = 1'b0;
  logic hpf_v = 1'b0;
  logic pmf_c = 1'b0;
  logic [1:0] coarse = 2'h0;
  logic [8:0] fine = 9'h000;
  logic [23:0] voff = 24'h000000;
  logic [23:0] coff = 24'h000000;
  logic [23:0] vg = 24'h400000;
  logic [23:0] cg = 24'h400000;
  logic [23:0] vs, cs, rv;
  logic [15:0] seed = 16'h62b0;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int vi, ci;
  int dly[4] = '{0, 1, 2, -1};

  always #50 clk = ~clk;

  mdd_modulator_model mdd_modulator_model_inst (.clk(clk), .reset_n(reset_n),
    .volt_level(lv), .curr_level(lc), .volt_bit(vbit), .curr_bit(cbit));

  mdd_datapath mdd_datapath_inst (.clk(clk), .reset_n(reset_n), .mod_volt_bit(vbit),
    .mod_curr_bit(cbit), .droop_filter_bypass(bypass), .coarse_phase_delay(coarse),
    .fine_phase_delay(fine), .hpf_volt_en(hpf_v), .hpf_curr_en(1'b0), .pmf_volt_en(1'b0),
    .pmf_curr_en(pmf_c), .volt_offset(voff), .curr_offset(coff), .volt_gain(vg),
    .curr_gain(cg), .sample_strobe(strobe), .volt_sample(vs), .curr_sample(cs));

  function automatic longint sat(input longint s);
    if (s > 64'sh7fffff) begin
      return 64'sh7fffff;
    end
    if (s < -64'sh800000) begin
      return -64'sh800000;
    end
    return s;
  endfunction

  function automatic logic [23:0] corr(input logic [23:0] x, input logic [23:0] o,
                                       input logic [23:0] g);
    longint s;
    s = sat(longint'($signed(x)) + longint'($signed(o)));
    s = sat((s * longint'({1'b0, g})) >>> 22);
    return s[23:0];
  endfunction

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic draw(output logic [23:0] v);
    seed = nx(seed);
    v[23:16] = seed[7:0];
    seed = nx(seed);
    v[15:0] = seed;
  endtask

  task automatic strobes(input int n);
    int t;
    repeat (n) begin
      t = 0;
      do begin
        @(posedge clk);
        #1;
        t++;
      end while (strobe !== 1'b1 && t < 1100);
      if (t >= 1100) begin
        $display("unexpected strobe expected 1 seen 0");
        fail_count++;
      end
    end
  endtask

  task automatic check(input string name, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", name, e, g);
      fail_count++;
    end
  endtask

  task automatic summarize();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    lc = 1'b1;
    bypass = 1'b1;
    voff = 24'h100000;
    coff = 24'hf00000;
    vg = 24'h200000;
    cg = 24'h200000;
    strobes(6);
    check("volt_sample", corr(24'h800000, voff, vg), vs);
    check("curr_sample", corr(24'h7fffff, coff, cg), cs);
    repeat (3) begin
      draw(voff);
      draw(coff);
      draw(vg);
      draw(cg);
      draw(rv);
      lv = rv[0];
      lc = rv[1];
      bypass = rv[2];
      fine = rv[11:3];
      strobes(6);
      check("volt_sample", corr(lv ? 24'h7fffff : 24'h800000, voff, vg), vs);
      check("curr_sample", corr(lc ? 24'h7fffff : 24'h800000, coff, cg), cs);
    end
    fine = 9'h000;
    bypass = 1'b0;
    voff = 24'h000000;
    coff = 24'h000000;
    vg = 24'h400000;
    cg = 24'h400000;
    for (int c = 0; c < 4; c++) begin
      coarse = c[1:0];
      lv = 1'b0;
      lc = 1'b0;
      strobes(5);
      lv = 1'b1;
      lc = 1'b1;
      vi = 99;
      ci = 99;
      for (int k = 0; k < 6; k++) begin
        strobes(1);
        if (vi == 99 && vs[23] === 1'b0) begin
          vi = k;
        end
        if (ci == 99 && cs[23] === 1'b0) begin
          ci = k;
        end
      end
      check("phase_offset", 24'(dly[c]), 24'(vi - ci));
    end
    // Mid-run reset clears the DC trackers; a steady full-scale input then
    // leaves a small positive DC estimate that the high-pass removes.
    coarse = 2'h0;
    lv = 1'b1;
    lc = 1'b1;
    hpf_v = 1'b1;
    pmf_c = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    strobes(6);
    check("hpf_volt_range", 24'h000001, {23'h0, (vs < 24'h7fffff) && (vs > 24'h7f0000)});
    check("pmf_curr_range", 24'h000001, {23'h0, (cs >= vs) && (cs < 24'h7fffff)});
    summarize();
  end
endmodule
